/* File: core/ecbe_pkg.sv */
// Constants, field layout and encodings for the execution-command interpreter.
// Notes on behaviour
// - Software reset acknowledges at once, then resets 100 ms later.
// - Software reset also leaves command mode.
// - Network reset acknowledges, then restarts the network layer discarding its state.
// - Network reset parameter is 0 for local node or 1 for broadcast.
// - Sleep-now puts a cyclic-sleep device to sleep without waiting.
// - Sleep-now acts only from API frames of type 0x08 or 0x09.
// - Sleep-now leaves command mode untouched.
// - Button simulation accepts counts 1, 2 or 4.
// - Table clear erases binding and group tables.
// - Discovery reports carry device type 0 coordinator, 1 router, 2 end device.
// - Discovery ends with a lone carriage return after timeout times 100 ms.
// - Discovery from an API frame sends packets without carriage returns.
// - Discovery with an identifier returns an error when nobody matches.
// - Error status 1 when four transmissions are already queued.
// - Lookup success in command mode loads destination, acknowledges, leaves command mode.
// - API lookup returns both addresses, errors on timeout or blank parameter.
// - Join disable defaults to 0, 1 blocks joins, lost on power cycle.
// - Input sample reads all enabled inputs at once.
// - A good entry sequence sends the bootloader menu at 115200 baud.
// - Serial traffic is 8N1 and flow control is off in the bootloader.
// - Command mode falls back to idle after the command-mode timeout.
// - Exit command leaves command mode at once and applies changes.
package ecbe_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam logic [7:0] BAUD_CYC = 8'(CLK_HZ / BAUD_RATE);
  localparam logic [7:0] BAUD_HALF = 8'(CLK_HZ / BAUD_RATE / 2);
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_DEST_HIGH = 8'h0C;
  localparam logic [7:0] REG_DEST_LOW = 8'h10;
  localparam logic [7:0] REG_NET_ADDR = 8'h14;
  // Command register fields.
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_PARAM_LSB = 4;
  localparam int CMD_API_LSB = 12;
  localparam int CMD_BLANK_BIT = 20;
  // Control register fields and reset values.
  localparam int CTRL_CT_LSB = 0;
  localparam int CTRL_NT_LSB = 16;
  localparam logic [15:0] CT_RESET = 16'h0064;
  localparam logic [7:0] NT_RESET = 8'h3C;
  localparam logic [7:0] API_NONE = 8'h00;
  localparam logic [7:0] API_AT_CMD = 8'h08;
  localparam logic [7:0] API_AT_QUEUE = 8'h09;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_ERR = 8'h01;
  localparam logic [1:0] DEV_COORD = 2'h0;
  localparam logic [1:0] DEV_ROUTER = 2'h1;
  localparam logic [1:0] DEV_END = 2'h2;
  localparam logic [2:0] QUEUE_MAX = 3'h4;
  localparam logic [7:0] CHAR_CR = 8'h0D;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_SOFT_RESET = 4'h1, CMD_NET_RESET = 4'h2, CMD_SLEEP_NOW = 4'h3,
    CMD_BUTTON = 4'h4, CMD_TABLE_CLEAR = 4'h5, CMD_NODE_DISC = 4'h6, CMD_DEST_LOOKUP = 4'h7,
    CMD_JOIN_DISABLE = 4'h8, CMD_INPUT_SAMPLE = 4'h9, CMD_EXIT = 4'hA, CMD_ENTER = 4'hB
  } ecbe_cmd_t;
  typedef enum logic [1:0] {EX_IDLE = 2'h0, EX_RESET_WAIT = 2'h1, EX_DISC = 2'h2, EX_LOOKUP = 2'h3} ecbe_exec_t;
  typedef enum logic [2:0] {
    BT_CHECK = 3'h0, BT_ARMED = 3'h1, BT_WAIT_CR = 3'h2, BT_ACTIVE = 3'h3, BT_OFF = 3'h4
  } ecbe_boot_t;
  typedef enum logic [1:0] {MSG_OK = 2'h0, MSG_ERR = 2'h1, MSG_CR = 2'h2, MSG_MENU = 2'h3} ecbe_msg_t;
endpackage : ecbe_pkg

/* File: core/ecbe_exec.sv */
// Execution-command interpreter with bootloader pin-sequence entry and serial reply transmitter.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ecbe_exec import ecbe_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic din_i,
  input wire logic sleep_request_pin_i,
  input wire logic rts_i,
  output logic data_out_o,
  input wire logic cyclic_sleep_i,
  input wire logic coord_i,
  input wire logic end_dev_i,
  input wire logic tx_done_i,
  input wire logic disc_match_i,
  input wire logic lookup_done_i,
  input wire logic [63:0] lookup_ext_i,
  input wire logic [15:0] lookup_net_i,
  output logic soft_reset_o,
  output logic net_restart_o,
  output logic net_broadcast_o,
  output logic sleep_now_o,
  output logic button_o,
  output logic [2:0] button_count_o,
  output logic table_clear_o,
  output logic sample_o,
  output logic disc_start_o,
  output logic lookup_start_o,
  output logic apply_o,
  output logic join_disable_o,
  output logic cmd_mode_o,
  output logic boot_mode_o
);

  // Message length in characters.
  function automatic logic [2:0] msg_len(input ecbe_msg_t sel);
    case (sel)
      MSG_OK: msg_len = 3'h3;
      MSG_ERR: msg_len = 3'h6;
      MSG_CR: msg_len = 3'h1;
      default: msg_len = 3'h4;
    endcase
  endfunction : msg_len

  // Message text, one character per index.
  function automatic logic [7:0] msg_char(input ecbe_msg_t sel, input logic [2:0] idx);
    logic [47:0] txt;
    txt = 48'h0;
    case (sel)
      MSG_OK: txt = {24'h0, 8'h4F, 8'h4B, CHAR_CR};
      MSG_ERR: txt = {8'h45, 8'h52, 8'h52, 8'h4F, 8'h52, CHAR_CR};
      MSG_CR: txt = {40'h0, CHAR_CR};
      default: txt = {16'h0, 8'h42, 8'h4C, 8'h3E, CHAR_CR};
    endcase
    msg_char = txt[8 * (msg_len(sel) - 3'h1 - idx) +: 8];
  endfunction : msg_char

  logic [2:0] pin_s1, pin_s2, pin_s3, pin_f;
  logic din_prev;
  logic [2:0] strap_cnt;
  ecbe_boot_t boot_st;
  logic menu_go;
  logic rx_busy, rx_done;
  logic [7:0] rx_cnt, rx_sh;
  logic [3:0] rx_bit;
  logic tx_busy, msg_active;
  logic [7:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [8:0] tx_sh;
  logic [2:0] msg_idx;
  ecbe_msg_t msg_sel, reply_sel;
  logic reply_go;
  logic [21:0] tick_cnt;
  logic [15:0] tick_n;
  ecbe_exec_t ex_st;
  logic [15:0] ct;
  logic [7:0] nt;
  logic [7:0] status;
  logic [31:0] dest_high, dest_low;
  logic [15:0] net_addr;
  logic [2:0] pend;
  logic api_cur, disc_ident, match_seen;
  logic [31:0] rd_mux;
  logic bus_req, cmd_wr, cmd_acc, pend_add, pend_full, transp;
  ecbe_cmd_t c_cmd;
  logic [7:0] c_param, c_api;
  logic c_blank;

  // Command register decode of the write currently on the bus.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmd_wr = bus_req & wb_we_i & (wb_adr_i == REG_CMD) & wb_sel_i[0];
  assign c_cmd = ecbe_cmd_t'(wb_dat_i[CMD_CODE_LSB +: 4]);
  assign c_param = wb_dat_i[CMD_PARAM_LSB +: 8];
  assign c_api = wb_dat_i[CMD_API_LSB +: 8];
  assign c_blank = wb_dat_i[CMD_BLANK_BIT];
  assign transp = (c_api == API_NONE);
  // Transparent commands other than enter need command mode; the bootloader owns the port once entered.
  assign cmd_acc = cmd_wr & (boot_st != BT_ACTIVE) & (ex_st == EX_IDLE) & (~transp | cmd_mode_o | c_cmd == CMD_ENTER);
  assign pend_full = (pend == QUEUE_MAX);
  assign pend_add = cmd_acc & ~pend_full & ((c_cmd == CMD_NODE_DISC) | (c_cmd == CMD_DEST_LOOKUP & ~c_blank)
                    | (c_cmd == CMD_NET_RESET & c_param == 8'h01));

  // Pin synchronisers; a level counts once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_f <= 3'h0;
      din_prev <= 1'b0;
    end else begin
      pin_s1 <= {rts_i, sleep_request_pin_i, din_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
      din_prev <= pin_f[0];
    end
  end

  // Bootloader entry: strap check after release, end of break, then a carriage return.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_cnt <= 3'h0;
      boot_st <= BT_CHECK;
      menu_go <= 1'b0;
      boot_mode_o <= 1'b0;
    end else begin
      menu_go <= 1'b0;
      case (boot_st)
        BT_CHECK: begin
          strap_cnt <= strap_cnt + 3'h1;
          if (strap_cnt == STRAP_SETTLE) begin
            boot_st <= (~pin_f[0] & ~pin_f[1] & pin_f[2]) ? BT_ARMED : BT_OFF;
          end
        end
        BT_ARMED: begin
          if (pin_f[1] | ~pin_f[2]) begin
            boot_st <= BT_OFF;
          end else if (pin_f[0]) begin
            boot_st <= BT_WAIT_CR;
          end
        end
        BT_WAIT_CR: begin
          if (rx_done && rx_sh == CHAR_CR) begin
            boot_st <= BT_ACTIVE;
            menu_go <= 1'b1;
            boot_mode_o <= 1'b1;
          end
        end
        BT_ACTIVE: boot_st <= BT_ACTIVE;
        default: boot_st <= BT_OFF;
      endcase
    end
  end

  // 8N1 receiver at 115200 baud; flow line is ignored here, a good stop bit marks a byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_cnt <= 8'h00;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (boot_st == BT_WAIT_CR && din_prev && !pin_f[0]) begin
          rx_busy <= 1'b1;
          rx_cnt <= BAUD_HALF;
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt == 8'h00) begin
        rx_cnt <= BAUD_CYC - 8'h01;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= pin_f[0];
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {pin_f[0], rx_sh[7:1]};
        end
      end else begin
        rx_cnt <= rx_cnt - 8'h01;
      end
    end
  end

  // 8N1 transmitter sending whole messages character by character.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_o <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt <= 8'h00;
      tx_bit <= 4'h0;
      tx_sh <= 9'h1FF;
      msg_active <= 1'b0;
      msg_idx <= 3'h0;
      msg_sel <= MSG_OK;
    end else begin
      if (menu_go || reply_go) begin
        msg_active <= 1'b1;
        msg_idx <= 3'h0;
        msg_sel <= menu_go ? MSG_MENU : reply_sel;
      end else if (msg_active && !tx_busy) begin
        tx_busy <= 1'b1;
        data_out_o <= 1'b0;
        tx_sh <= {1'b1, msg_char(msg_sel, msg_idx)};
        tx_cnt <= BAUD_CYC - 8'h01;
        tx_bit <= 4'h0;
        msg_idx <= msg_idx + 3'h1;
        msg_active <= (msg_idx != msg_len(msg_sel) - 3'h1);
      end
      if (tx_busy) begin
        if (tx_cnt != 8'h00) begin
          tx_cnt <= tx_cnt - 8'h01;
        end else if (tx_bit == 4'h9) begin
          tx_busy <= 1'b0;
        end else begin
          data_out_o <= tx_sh[0];
          tx_sh <= {1'b1, tx_sh[8:1]};
          tx_bit <= tx_bit + 4'h1;
          tx_cnt <= BAUD_CYC - 8'h01;
        end
      end
    end
  end

  // 100 ms tick counter, restarted by every accepted command.
  always_ff @(posedge clk_i) begin
    if (rst_i || cmd_acc) begin
      tick_cnt <= 22'h0;
      tick_n <= 16'h0;
    end else if (tick_cnt == 22'(TICK_CYCLES - 1)) begin
      tick_cnt <= 22'h0;
      tick_n <= (tick_n == 16'hFFFF) ? tick_n : tick_n + 16'h1;
    end else begin
      tick_cnt <= tick_cnt + 22'h1;
    end
  end

  // Transmit queue occupancy; a finished transmission frees a slot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 3'h0;
    end else begin
      pend <= pend + {2'h0, pend_add} - {2'h0, tx_done_i & (pend != 3'h0)};
    end
  end

  // Command execution, command mode and the lasting results of commands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ex_st <= EX_IDLE;
      cmd_mode_o <= 1'b0;
      status <= STAT_OK;
      reply_go <= 1'b0;
      reply_sel <= MSG_OK;
      join_disable_o <= 1'b0;
      dest_high <= 32'h0;
      dest_low <= 32'h0;
      net_addr <= 16'h0;
      api_cur <= 1'b0;
      disc_ident <= 1'b0;
      match_seen <= 1'b0;
      soft_reset_o <= 1'b0;
      net_restart_o <= 1'b0;
      net_broadcast_o <= 1'b0;
      sleep_now_o <= 1'b0;
      button_o <= 1'b0;
      button_count_o <= 3'h0;
      table_clear_o <= 1'b0;
      sample_o <= 1'b0;
      disc_start_o <= 1'b0;
      lookup_start_o <= 1'b0;
      apply_o <= 1'b0;
    end else begin
      reply_go <= 1'b0;
      soft_reset_o <= 1'b0;
      net_restart_o <= 1'b0;
      net_broadcast_o <= 1'b0;
      sleep_now_o <= 1'b0;
      button_o <= 1'b0;
      table_clear_o <= 1'b0;
      sample_o <= 1'b0;
      disc_start_o <= 1'b0;
      lookup_start_o <= 1'b0;
      apply_o <= 1'b0;
      if (cmd_acc) begin
        api_cur <= ~transp;
        status <= STAT_OK;
        reply_go <= transp;
        reply_sel <= MSG_OK;
        case (c_cmd)
          CMD_SOFT_RESET: ex_st <= EX_RESET_WAIT;
          CMD_NET_RESET: begin
            if (c_param > 8'h01 || (c_param == 8'h01 && pend_full)) begin
              status <= STAT_ERR;
              reply_sel <= MSG_ERR;
            end else begin
              net_restart_o <= 1'b1;
              net_broadcast_o <= c_param[0];
            end
          end
          CMD_SLEEP_NOW: sleep_now_o <= (c_api == API_AT_CMD || c_api == API_AT_QUEUE) & cyclic_sleep_i;
          CMD_BUTTON: begin
            if (c_param == 8'h01 || c_param == 8'h02 || c_param == 8'h04) begin
              button_o <= 1'b1;
              button_count_o <= c_param[2:0];
            end else begin
              status <= STAT_ERR;
              reply_sel <= MSG_ERR;
            end
          end
          CMD_TABLE_CLEAR: table_clear_o <= 1'b1;
          CMD_NODE_DISC: begin
            if (pend_full) begin
              status <= STAT_ERR;
              reply_sel <= MSG_ERR;
            end else begin
              reply_go <= 1'b0;
              disc_start_o <= 1'b1;
              disc_ident <= ~c_blank;
              match_seen <= 1'b0;
              ex_st <= EX_DISC;
            end
          end
          CMD_DEST_LOOKUP: begin
            if (c_blank || pend_full) begin
              status <= STAT_ERR;
              reply_sel <= MSG_ERR;
            end else begin
              reply_go <= 1'b0;
              lookup_start_o <= 1'b1;
              ex_st <= EX_LOOKUP;
            end
          end
          CMD_JOIN_DISABLE: begin
            if (c_param > 8'h01) begin
              status <= STAT_ERR;
              reply_sel <= MSG_ERR;
            end else begin
              join_disable_o <= c_param[0];
            end
          end
          CMD_INPUT_SAMPLE: sample_o <= 1'b1;
          CMD_EXIT: begin
            cmd_mode_o <= 1'b0;
            apply_o <= 1'b1;
          end
          CMD_ENTER: cmd_mode_o <= 1'b1;
          default: begin
            status <= STAT_ERR;
            reply_sel <= MSG_ERR;
          end
        endcase
      end else begin
        case (ex_st)
          EX_RESET_WAIT: begin
            if (tick_n == 16'h1) begin
              soft_reset_o <= 1'b1;
              cmd_mode_o <= 1'b0;
              ex_st <= EX_IDLE;
            end
          end
          EX_DISC: begin
            if (disc_match_i) begin
              match_seen <= 1'b1;
            end
            if (tick_n == {8'h0, nt}) begin
              ex_st <= EX_IDLE;
              reply_go <= ~api_cur;
              if (disc_ident && !match_seen && !disc_match_i) begin
                status <= STAT_ERR;
                reply_sel <= MSG_ERR;
              end else begin
                reply_sel <= MSG_CR;
              end
            end
          end
          EX_LOOKUP: begin
            if (lookup_done_i) begin
              dest_high <= lookup_ext_i[63:32];
              dest_low <= lookup_ext_i[31:0];
              net_addr <= lookup_net_i;
              reply_go <= ~api_cur;
              reply_sel <= MSG_OK;
              cmd_mode_o <= api_cur & cmd_mode_o;
              ex_st <= EX_IDLE;
            end else if (tick_n == {8'h0, nt}) begin
              status <= STAT_ERR;
              reply_go <= ~api_cur;
              reply_sel <= MSG_ERR;
              ex_st <= EX_IDLE;
            end
          end
          default: begin
            if (cmd_mode_o && tick_n >= ct) begin
              cmd_mode_o <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Register read mux; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      REG_STATUS: rd_mux = {13'h0, pend, status, 2'h0, (coord_i ? DEV_COORD : end_dev_i ? DEV_END : DEV_ROUTER),
                            join_disable_o, boot_mode_o, (ex_st != EX_IDLE), cmd_mode_o};
      REG_CTRL: rd_mux = {8'h0, nt, ct};
      REG_DEST_HIGH: rd_mux = dest_high;
      REG_DEST_LOW: rd_mux = dest_low;
      REG_NET_ADDR: rd_mux = {16'h0, net_addr};
      default: rd_mux = 32'h0;
    endcase
  end

  // Wishbone slave: one wait state, acknowledge for one cycle, control register writes by byte lane.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ct <= CT_RESET;
      nt <= NT_RESET;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h0;
      if (bus_req && wb_we_i && wb_adr_i == REG_CTRL) begin
        if (wb_sel_i[0]) ct[7:0] <= wb_dat_i[CTRL_CT_LSB +: 8];
        if (wb_sel_i[1]) ct[15:8] <= wb_dat_i[CTRL_CT_LSB + 8 +: 8];
        if (wb_sel_i[2]) nt <= wb_dat_i[CTRL_NT_LSB +: 8];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fr_taken;
    cmd_acc && c_cmd == CMD_SOFT_RESET;
  endsequence
  sequence s_fr_done;
    soft_reset_o && !cmd_mode_o ##1 !cmd_mode_o;
  endsequence

  property p_fr_reply;
    s_fr_taken |=> status == STAT_OK && !soft_reset_o && ex_st == EX_RESET_WAIT;
  endproperty
  a_fr_reply: assert property (p_fr_reply) else $error("soft reset not acknowledged at once");

  property p_fr_exit;
    soft_reset_o |-> $past(ex_st) == EX_RESET_WAIT ##1 !cmd_mode_o;
  endproperty
  a_fr_exit: assert property (p_fr_exit) else $error("soft reset left command mode set");

  property p_nr_param;
    cmd_acc && c_cmd == CMD_NET_RESET && c_param > 8'h01 |=> status == STAT_ERR && !net_restart_o;
  endproperty
  a_nr_param: assert property (p_nr_param) else $error("bad network reset parameter accepted");

  property p_sleep_transp;
    cmd_acc && c_cmd == CMD_SLEEP_NOW && transp |=> !sleep_now_o && $stable(cmd_mode_o);
  endproperty
  a_sleep_transp: assert property (p_sleep_transp) else $error("sleep-now acted in transparent mode");

  property p_button;
    button_o |-> button_count_o == 3'h1 || button_count_o == 3'h2 || button_count_o == 3'h4;
  endproperty
  a_button: assert property (p_button) else $error("illegal button press count");

  property p_queue_full;
    cmd_acc && c_cmd == CMD_NODE_DISC && pend == QUEUE_MAX |=> status == STAT_ERR && !disc_start_o;
  endproperty
  a_queue_full: assert property (p_queue_full) else $error("full queue did not give error 1");

  property p_dn_transp;
    ex_st == EX_LOOKUP && lookup_done_i && !api_cur |=> !cmd_mode_o && reply_go && ex_st == EX_IDLE;
  endproperty
  a_dn_transp: assert property (p_dn_transp) else $error("lookup success kept command mode");

  property p_exit;
    cmd_acc && c_cmd == CMD_EXIT |=> apply_o && !cmd_mode_o;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not leave and apply");

  property p_filter;
    pin_f[0] != $past(pin_f[0]) |-> $past(pin_s2[0]) == $past(pin_s3[0]);
  endproperty
  a_filter: assert property (p_filter) else $error("pin level changed without agreement");

endmodule : ecbe_exec
`default_nettype wire

/* File: testbench/ecbe_host.sv */
// Host-side serial model that drives the strap pins and sends 8N1 frames.
`timescale 1ns/1ps
`default_nettype none
module ecbe_host import ecbe_pkg::*; (
  input wire logic clk_i,
  output var logic din_o,
  output var logic sleep_o,
  output var logic rts_o
);
  // Break on the data line, sleep request low and flow line high from power-up.
  initial begin
    din_o = 1'b0;
    sleep_o = 1'b0;
    rts_o = 1'b1;
  end
  // Moves all three pins together just after an edge.
  task automatic pins(input logic d, input logic s, input logic r);
    @(posedge clk_i);
    din_o <= d;
    sleep_o <= s;
    rts_o <= r;
  endtask : pins
  // Ends the break with two idle bits, then one frame: start, eight bits LSB first, stop.
  task automatic send(input logic [7:0] b);
    logic [11:0] g;
    g = {1'b1, b, 1'b0, 2'b11};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      din_o <= g[i];
      repeat (BAUD_CYC - 1) @(posedge clk_i);
    end
  endtask : send
endmodule : ecbe_host
`default_nettype wire

/* File: testbench/ecbe_tb_top.sv */
// Self-checking bench for the execution-command interpreter and boot entry.
`timescale 1ns/1ps
`default_nettype none
module exec_command_and_boot_entry_tb_top import ecbe_pkg::*;;
  localparam int TICK = 50;
  typedef struct {logic [31:0] cmd; logic [7:0] st; logic [6:0] pul;} ecbe_row_t;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, dout, bm, cm, jd, din, slp, rts;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic csl = 1'b1, crd = 1'b0, txd = 1'b0;
  logic [31:0] dat = 32'h0, q, rd;
  logic [6:0] pul, seen = 7'h00;
  int err_count = 0, num_checks = 0, cyc_cnt = 0, n;
  ecbe_row_t rows [18];
  ecbe_host host (.clk_i(clk), .din_o(din), .sleep_o(slp), .rts_o(rts));
  ecbe_exec #(.TICK_CYCLES(TICK)) uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rd), .din_i(din),
    .sleep_request_pin_i(slp), .rts_i(rts), .data_out_o(dout), .cyclic_sleep_i(csl), .coord_i(crd),
    .end_dev_i(1'b1), .tx_done_i(txd), .disc_match_i(1'b0), .lookup_done_i(1'b0), .lookup_ext_i(64'h0),
    .lookup_net_i(16'h0), .soft_reset_o(pul[6]), .net_restart_o(pul[5]), .net_broadcast_o(pul[4]),
    .sleep_now_o(pul[3]), .button_o(pul[2]), .button_count_o(), .table_clear_o(pul[1]), .sample_o(pul[0]),
    .disc_start_o(), .lookup_start_o(), .apply_o(), .join_disable_o(jd), .cmd_mode_o(cm), .boot_mode_o(bm));
  // Clock of 40 ns period.
  initial forever #20 clk = ~clk;
  // Collects pulses seen since the last bus request was made.
  always @(posedge clk) seen <= (cyc && !ack) ? 7'h00 : (seen | pul);
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // One classic Wishbone cycle; holds the request until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Boot entry, register defaults, command table, then soft reset timing.
  initial begin
    rows = '{'{32'h08002, STAT_OK, 7'h20}, '{32'h08022, STAT_ERR, 7'h00}, '{32'h08003, STAT_OK, 7'h08},
      '{32'h09003, STAT_OK, 7'h08}, '{32'h08014, STAT_OK, 7'h04}, '{32'h08024, STAT_OK, 7'h04},
      '{32'h08044, STAT_OK, 7'h04}, '{32'h08034, STAT_ERR, 7'h00}, '{32'h08005, STAT_OK, 7'h02},
      '{32'h08009, STAT_OK, 7'h01}, '{32'h08018, STAT_OK, 7'h00}, '{32'h0000B, STAT_OK, 7'h00},
      '{32'h00003, STAT_OK, 7'h00}, '{32'h08012, STAT_OK, 7'h30}, '{32'h08012, STAT_OK, 7'h30},
      '{32'h08012, STAT_OK, 7'h30}, '{32'h08012, STAT_OK, 7'h30}, '{32'h08012, STAT_ERR, 7'h00}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    host.send(CHAR_CR);
    for (n = 0; n < 100 && bm !== 1'b1; n++) @(posedge clk);
    chk(bm, 1);
    for (n = 0; n < 2000 && dout !== 1'b0; n++) @(posedge clk);
    repeat (BAUD_HALF) @(posedge clk);
    chk(dout, 0);
    repeat (BAUD_CYC) @(posedge clk);
    chk(dout, 0);
    repeat (BAUD_CYC) @(posedge clk);
    chk(dout, 1);
    $display("boot entry done");
    host.pins(1'b1, 1'b1, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h003C0064);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[3:0], 0);
    for (int i = 0; i < 18; i++) begin
      wb(1'b1, REG_CMD, rows[i].cmd);
      repeat (2) @(posedge clk);
      chk(seen, rows[i].pul);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[15:8], rows[i].st);
    end
    chk(q[18:16], QUEUE_MAX);
    chk(q[5:4], DEV_END);
    chk(jd, 1);
    chk(cm, 1);
    // A finished transmission frees one queue slot.
    txd <= 1'b1;
    @(posedge clk);
    txd <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[18:16], 32'h3);
    $display("command table done");
    wb(1'b1, REG_CMD, 32'h08001);
    for (n = 0; n < 3 * TICK && pul[6] !== 1'b1; n++) @(posedge clk);
    chk(n > TICK - 4 && n < TICK + 2, 1);
    repeat (2) @(posedge clk);
    chk(cm, 0);
    $display("soft reset done");
    results();
  end
endmodule : exec_command_and_boot_entry_tb_top
`default_nettype wire
